//--- logic/pktz_pkg.sv
// Functional notes
// - Host bytes are forwarded unchanged as radio packets.
// - No identifier is added and nothing is sent without host data.
// - While sleep enable is high the block sleeps and ignores serial data.
// - With sleep enable low the block wakes and listens for serial bytes.
// - The activity indicator goes low once the first byte of a transfer arrives.
// - The activity indicator returns high only when all buffered data has been sent.
// - Sleep enable is sampled only while no transmission is in progress (indicator high, buffer and output empty).
// - A transfer shorter than 60 bytes is sent as one packet once it is complete.
// - A longer transfer is cut into 60-byte packets sent one after another.
// - Up to 256 received bytes are held in the buffer.
// - Packets are drained while bytes still arrive so streaming has no length limit.
// - Parity is none, even or odd, none by default.
package pktz_pkg;
    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned BAUD_DEFAULT  = 9600;
    localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_DEFAULT;
    localparam int unsigned PKT_MAX       = 60;
    localparam int unsigned BUF_DEPTH     = 256;
    localparam int unsigned GAP_CHARS     = 3;
    localparam int unsigned CHAR_BITS     = 11;
    localparam int unsigned GAP_CYCLES    = GAP_CHARS * CHAR_BITS * BIT_CYCLES;
    localparam logic [1:0]  PAR_NONE      = 2'h0;
    localparam logic [1:0]  PAR_EVEN      = 2'h1;
    localparam logic [1:0]  PAR_ODD       = 2'h2;
    localparam logic [1:0]  PAR_DEFAULT   = PAR_NONE;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parityErr;
        logic       frameErr;
    } rx_char_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       first;
        logic       last;
    } radio_byte_s;
endpackage : pktz_pkg

//--- logic/serial_char_rx.sv
`timescale 1ns/1ps
module serial_char_rx #(
    parameter int unsigned BIT_CYC = pktz_pkg::BIT_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    input  wire logic              listen,
    input  wire logic [1:0]        paritySel,
    input  wire logic              serialSync,
    output pktz_pkg::rx_char_s     rxChar
);
    // ------------------------------------------------------------
    // Receive state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

    rx_state_e          state_reg, state_next;
    logic [15:0]        cnt_reg, cnt_next;
    logic [2:0]         bit_reg, bit_next;
    logic [7:0]         sh_reg, sh_next;
    logic               perr_reg, perr_next;
    pktz_pkg::rx_char_s out_reg, out_next;

    localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF = 16'(BIT_CYC / 2);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        bit_next   = bit_reg;
        sh_next    = sh_reg;
        perr_next  = perr_reg;
        out_next   = '0;
        if (cnt_reg != 16'h0) begin
            cnt_next = cnt_reg - 16'h1;
        end
        case (state_reg)
            RX_IDLE: begin
                if (listen && !serialSync) begin
                    state_next = RX_START;
                    cnt_next   = HALF;
                end
            end
            RX_START: begin
                if (cnt_reg == 16'h0) begin
                    state_next = serialSync ? RX_IDLE : RX_DATA;
                    cnt_next   = FULL;
                    bit_next   = 3'h0;
                end
            end
            RX_DATA: begin
                if (cnt_reg == 16'h0) begin
                    sh_next  = {serialSync, sh_reg[7:1]};
                    cnt_next = FULL;
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        state_next = (paritySel == pktz_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
                    end
                end
            end
            RX_PAR: begin
                if (cnt_reg == 16'h0) begin
                    perr_next  = (^sh_reg ^ serialSync) != (paritySel == pktz_pkg::PAR_ODD);
                    state_next = RX_STOP;
                    cnt_next   = FULL;
                end
            end
            RX_STOP: begin
                if (cnt_reg == 16'h0) begin
                    out_next.valid     = 1'b1;
                    out_next.data      = sh_reg;
                    out_next.parityErr = perr_reg;
                    out_next.frameErr  = !serialSync;
                    perr_next          = 1'b0;
                    state_next         = RX_IDLE;
                end
            end
            default: state_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= RX_IDLE;
            cnt_reg   <= 16'h0;
            bit_reg   <= 3'h0;
            sh_reg    <= 8'h0;
            perr_reg  <= 1'b0;
            out_reg   <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            bit_reg   <= bit_next;
            sh_reg    <= sh_next;
            perr_reg  <= perr_next;
            out_reg   <= out_next;
        end
    end

    assign rxChar = out_reg;

    a_rx_idle_quiet : assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_reg == RX_IDLE) |-> !out_reg.valid || $past(state_reg) == RX_STOP || !$past(clkEn))
        else $error("char valid without stop bit");
endmodule : serial_char_rx

//--- logic/serial_to_radio_packetizer.sv
`timescale 1ns/1ps
module serial_to_radio_packetizer #(
    parameter int unsigned BIT_CYC = pktz_pkg::BIT_CYCLES,
    parameter int unsigned GAP_CYC = pktz_pkg::GAP_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    input  wire logic [1:0]        paritySel,
    input  wire logic              sleep_enable_in,
    input  wire logic              host_serial_in,
    input  wire logic              radioReady,
    output pktz_pkg::radio_byte_s  radioOut,
    output logic                   activityInd,
    output logic                   sleeping,
    output logic                   charDropped
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sleepSync_reg, serSync_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepSync_reg <= 2'h3;
            serSync_reg   <= 2'h3;
        end else if (clkEn) begin
            sleepSync_reg <= {sleepSync_reg[0], sleep_enable_in};
            serSync_reg   <= {serSync_reg[0], host_serial_in};
        end
    end

    // ------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------
    pktz_pkg::rx_char_s rxChar;
    logic               awake_reg, awake_next;

    serial_char_rx #(.BIT_CYC(BIT_CYC)) u_rx (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .clkEn      (clkEn),
        .listen     (awake_reg),
        .paritySel  (paritySel),
        .serialSync (serSync_reg[1]),
        .rxChar     (rxChar)
    );

    // ------------------------------------------------------------
    // Buffer and packet control
    // ------------------------------------------------------------
    logic [7:0]  mem [pktz_pkg::BUF_DEPTH];
    logic [7:0]  wr_reg, wr_next, rd_reg, rd_next;
    logic [8:0]  cnt_reg, cnt_next;
    logic [5:0]  pkt_reg, pkt_next;
    logic [31:0] gap_reg, gap_next;
    logic        xferEnd_reg, xferEnd_next;
    logic        act_reg, act_next;
    logic        drop_reg, drop_next;
    pktz_pkg::radio_byte_s out_reg, out_next;
    logic        push, pop, outFree;

    localparam logic [8:0] DEPTH = 9'(pktz_pkg::BUF_DEPTH);
    localparam logic [5:0] PMAX  = 6'(pktz_pkg::PKT_MAX);

    assign outFree = !out_reg.valid || radioReady;
    assign push    = rxChar.valid && !rxChar.parityErr && !rxChar.frameErr && cnt_reg != DEPTH;
    // Start a packet only on 60 bytes or a finished transfer; continue one in progress
    assign pop     = outFree && cnt_reg != 9'h0 &&
                     (pkt_reg != 6'h0 || cnt_reg >= 9'(PMAX) || xferEnd_reg);

    always_comb begin
        awake_next   = awake_reg;
        wr_next      = wr_reg;
        rd_next      = rd_reg;
        cnt_next     = cnt_reg;
        pkt_next     = pkt_reg;
        gap_next     = gap_reg;
        xferEnd_next = xferEnd_reg;
        act_next     = act_reg;
        drop_next    = rxChar.valid && !rxChar.parityErr && !rxChar.frameErr && cnt_reg == DEPTH;
        out_next     = out_reg;
        if (radioReady) begin
            out_next.valid = 1'b0;
        end
        if (push) begin
            wr_next      = wr_reg + 8'h1;
            xferEnd_next = 1'b0;
            gap_next     = 32'(GAP_CYC);
            act_next     = 1'b0;
        end else if (gap_reg != 32'h0) begin
            gap_next = gap_reg - 32'h1;
            if (gap_reg == 32'h1) begin
                xferEnd_next = 1'b1;
            end
        end
        if (pop) begin
            out_next.valid = 1'b1;
            out_next.data  = mem[rd_reg];
            out_next.first = pkt_reg == 6'h0;
            out_next.last  = pkt_reg == PMAX - 6'h1 || cnt_reg == 9'h1;
            rd_next        = rd_reg + 8'h1;
            pkt_next       = out_next.last ? 6'h0 : pkt_reg + 6'h1;
        end
        cnt_next = cnt_reg + {8'h0, push} - {8'h0, pop};
        // Idle means buffer drained, radio done and transfer closed
        if (!act_reg && cnt_next == 9'h0 && !out_next.valid && pkt_next == 6'h0
            && (xferEnd_next || !awake_reg)) begin
            act_next = 1'b1;
        end
        if (act_reg && cnt_reg == 9'h0 && !out_reg.valid) begin
            awake_next = !sleepSync_reg[1];
        end
    end

    always_ff @(posedge core_clk) begin
        if (clkEn && push) begin
            mem[wr_reg] <= rxChar.data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awake_reg   <= 1'b0;
            wr_reg      <= 8'h0;
            rd_reg      <= 8'h0;
            cnt_reg     <= 9'h0;
            pkt_reg     <= 6'h0;
            gap_reg     <= 32'h0;
            xferEnd_reg <= 1'b0;
            act_reg     <= 1'b1;
            drop_reg    <= 1'b0;
            out_reg     <= '0;
        end else if (clkEn) begin
            awake_reg   <= awake_next;
            wr_reg      <= wr_next;
            rd_reg      <= rd_next;
            cnt_reg     <= cnt_next;
            pkt_reg     <= pkt_next;
            gap_reg     <= gap_next;
            xferEnd_reg <= xferEnd_next;
            act_reg     <= act_next;
            drop_reg    <= drop_next;
            out_reg     <= out_next;
        end
    end

    assign radioOut    = out_reg;
    assign activityInd = act_reg;
    assign sleeping    = !awake_reg;
    assign charDropped = drop_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sleep_no_push : assert property (@(posedge core_clk) disable iff (!rst_b)
        !awake_reg && cnt_reg == 9'h0 |-> !rxChar.valid || $past(awake_reg))
        else $error("byte taken while asleep");
    a_wake_on_low : assert property (@(posedge core_clk) disable iff (!rst_b)
        clkEn && act_reg && cnt_reg == 9'h0 && !out_reg.valid && !sleepSync_reg[1] |=> awake_reg)
        else $error("did not wake");
    a_act_low_push : assert property (@(posedge core_clk) disable iff (!rst_b)
        clkEn && push |=> !act_reg)
        else $error("indicator not low after byte");
    a_act_high_empty : assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(act_reg) |-> cnt_reg == 9'h0 && !out_reg.valid)
        else $error("indicator high with data pending");
    a_sleep_held_busy : assert property (@(posedge core_clk) disable iff (!rst_b)
        !act_reg && awake_reg |=> awake_reg)
        else $error("slept during transfer");
    a_pkt_limit : assert property (@(posedge core_clk) disable iff (!rst_b)
        pkt_reg < PMAX)
        else $error("packet over 60 bytes");
    a_short_wait : assert property (@(posedge core_clk) disable iff (!rst_b)
        pop && pkt_reg == 6'h0 |-> cnt_reg >= 9'(PMAX) || xferEnd_reg)
        else $error("short packet started early");
    a_buf_bound : assert property (@(posedge core_clk) disable iff (!rst_b)
        cnt_reg <= DEPTH)
        else $error("buffer overflow");
    a_last_first : assert property (@(posedge core_clk) disable iff (!rst_b)
        clkEn && pop && out_next.last |=> pkt_reg == 6'h0)
        else $error("packet count not cleared");

    c_full_packet : cover property (@(posedge core_clk) pop && pkt_reg == PMAX - 6'h1);
    c_short_end   : cover property (@(posedge core_clk) $rose(xferEnd_reg));
    c_buf_full    : cover property (@(posedge core_clk) cnt_reg == DEPTH);
    c_act_cycle   : cover property (@(posedge core_clk) $rose(act_reg));
endmodule : serial_to_radio_packetizer

//--- verif/host_uart_model.sv
`timescale 1ns/1ps
module host_uart_model #(
    parameter int unsigned BIT_CYC = 8
) (
    input  wire logic core_clk,
    output logic      serialLine,
    output logic      sleepLine
);
    // ------------------------------------------------------------
    // Idle line high, module held asleep
    // ------------------------------------------------------------
    initial begin
        serialLine = 1'b1;
        sleepLine  = 1'b1;
    end

    task automatic set_sleep(input logic v);
        @(posedge core_clk);
        sleepLine <= v;
    endtask : set_sleep

    // Start bit, LSB first, optional parity, one stop bit
    task automatic send_char(input logic [7:0] data, input logic [1:0] par, input logic flip);
        logic [10:0] frame;
        int          nBits;
        logic        pBit;
        pBit  = (^data) ^ (par == pktz_pkg::PAR_ODD) ^ flip;
        frame = (par == pktz_pkg::PAR_NONE) ? {1'b1, ~flip, data, 1'b0} : {1'b1, pBit, data, 1'b0};
        nBits = (par == pktz_pkg::PAR_NONE) ? 10 : 11;
        @(posedge core_clk);
        for (int i = 0; i < nBits; i++) begin
            serialLine <= frame[i];
            repeat (BIT_CYC) @(posedge core_clk);
        end
        serialLine <= 1'b1;
    endtask : send_char
endmodule : host_uart_model

//--- verif/serial_to_radio_packetizer_tb.sv
`timescale 1ns/1ps
module serial_to_radio_packetizer_tb;
    logic                  core_clk;
    logic                  rst_b;
    logic                  clkEn;
    logic [1:0]            paritySel;
    logic                  serialLine;
    logic                  sleepLine;
    logic                  radioReady;
    logic                  holdOff;
    logic                  stallOn;
    pktz_pkg::radio_byte_s radioOut;
    logic                  activityInd;
    logic                  sleeping;
    logic                  charDropped;
    pktz_pkg::radio_byte_s gotQ[$];
    int                    dropCnt;
    int                    err_total;
    int                    n_tests;

    serial_to_radio_packetizer #(.BIT_CYC(8), .GAP_CYC(300)) serial_to_radio_packetizer_inst (
        .core_clk        (core_clk),
        .rst_b           (rst_b),
        .clkEn           (clkEn),
        .paritySel       (paritySel),
        .sleep_enable_in (sleepLine),
        .host_serial_in  (serialLine),
        .radioReady      (radioReady),
        .radioOut        (radioOut),
        .activityInd     (activityInd),
        .sleeping        (sleeping),
        .charDropped     (charDropped)
    );

    host_uart_model #(.BIT_CYC(8)) host_inst (
        .core_clk   (core_clk),
        .serialLine (serialLine),
        .sleepLine  (sleepLine)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Radio sink
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (radioOut.valid === 1'b1 && radioReady === 1'b1) begin
            gotQ.push_back(radioOut);
        end
        if (charDropped === 1'b1) begin
            dropCnt++;
        end
        radioReady <= holdOff ? 1'b0 : (stallOn ? ~radioReady : 1'b1);
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("mismatches %0d, checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic wait_idle();
        int k;
        k = 0;
        while (activityInd !== 1'b1 && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        check(k < 20000, 1, "indicator stuck low");
    endtask : wait_idle

    task automatic wake();
        int k;
        k = 0;
        host_inst.set_sleep(1'b0);
        while (sleeping !== 1'b0 && k < 50) begin
            @(posedge core_clk);
            k++;
        end
        check(sleeping, 0, "no wake");
    endtask : wake

    task automatic expect_pkts(input int n, input logic [7:0] base);
        check(gotQ.size(), n, "byte count");
        for (int i = 0; i < gotQ.size() && i < n; i++) begin
            check(gotQ[i].data, 8'(base + i[7:0]), "data");
            check(gotQ[i].first, (i % 60) == 0, "first flag");
            check(gotQ[i].last, (i % 60) == 59 || i == n - 1, "last flag");
        end
        gotQ.delete();
    endtask : expect_pkts

    task automatic send_run(input int n, input logic [7:0] base, input logic [1:0] par);
        for (int i = 0; i < n; i++) begin
            host_inst.send_char(8'(base + i[7:0]), par, 1'b0);
        end
    endtask : send_run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_asleep();
        check(sleeping, 1, "reset sleep");
        check(radioOut, 0, "reset radio");
        host_inst.send_char(8'h33, pktz_pkg::PAR_NONE, 1'b0);
        repeat (400) @(posedge core_clk);
        check(activityInd, 1, "asleep activity");
        check(gotQ.size(), 0, "asleep sent");
    endtask : t_asleep

    task automatic t_short_sleep_early();
        host_inst.send_char(8'h10, pktz_pkg::PAR_NONE, 1'b0);
        repeat (4) @(posedge core_clk);
        check(activityInd, 0, "indicator after first byte");
        send_run(2, 8'h11, pktz_pkg::PAR_NONE);
        host_inst.set_sleep(1'b1);
        repeat (4) @(posedge core_clk);
        check(sleeping, 0, "slept before send");
        wait_idle();
        expect_pkts(3, 8'h10);
        repeat (10) @(posedge core_clk);
        check(sleeping, 1, "no sleep after send");
        wake();
    endtask : t_short_sleep_early

    task automatic t_long_stalled();
        stallOn <= 1'b1;
        send_run(62, 8'h40, pktz_pkg::PAR_NONE);
        wait_idle();
        stallOn <= 1'b0;
        expect_pkts(62, 8'h40);
    endtask : t_long_stalled

    task automatic t_parity();
        for (int p = 0; p < 3; p++) begin
            paritySel <= p[1:0];
            host_inst.send_char(8'h80, p[1:0], 1'b0);
            host_inst.send_char(8'h81, p[1:0], 1'b1);
            host_inst.send_char(8'h81, p[1:0], 1'b0);
            wait_idle();
            expect_pkts(2, 8'h80);
        end
        paritySel <= pktz_pkg::PAR_NONE;
    endtask : t_parity

    task automatic t_freeze();
        clkEn <= 1'b0;
        host_inst.set_sleep(1'b1);
        host_inst.send_char(8'h5a, pktz_pkg::PAR_NONE, 1'b0);
        repeat (4) @(posedge core_clk);
        check(sleeping, 0, "sleep while frozen");
        check(activityInd, 1, "byte while frozen");
        clkEn <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(sleeping, 1, "no sleep after thaw");
        check(gotQ.size(), 0, "frozen sent");
        wake();
    endtask : t_freeze

    // Output stage holds one byte beyond the full buffer
    task automatic t_overflow();
        holdOff <= 1'b1;
        dropCnt = 0;
        send_run(258, 8'h00, pktz_pkg::PAR_NONE);
        repeat (4) @(posedge core_clk);
        check(dropCnt, 1, "drop count");
        holdOff <= 1'b0;
        wait_idle();
        expect_pkts(257, 8'h00);
    endtask : t_overflow

    initial begin
        rst_b      = 1'b0;
        clkEn      = 1'b1;
        paritySel  = pktz_pkg::PAR_DEFAULT;
        radioReady = 1'b0;
        holdOff    = 1'b0;
        stallOn    = 1'b0;
        dropCnt    = 0;
        err_total  = 0;
        n_tests    = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_asleep();
        wake();
        t_short_sleep_early();
        t_long_stalled();
        t_parity();
        t_freeze();
        t_overflow();
        stop_test();
    end

    initial begin
        repeat (80000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
endmodule : serial_to_radio_packetizer_tb
